// ===== inc/dsm_defs.vh
`ifndef DSM_DEFS_VH
`define DSM_DEFS_VH

// register indices; byte address is four times the index
`define DSM_IDX_STAT_LO     8'h08
`define DSM_IDX_REQ_LO      8'h09
`define DSM_IDX_SMASK_LO    8'h0a
`define DSM_IDX_AMASK_LO    8'h0f
`define DSM_IDX_STAT_HI     8'hd0
`define DSM_IDX_REQ_HI      8'hd2
`define DSM_IDX_SMASK_HI    8'hd4
`define DSM_IDX_AMASK_HI    8'hde
`define DSM_IDX_MCLR        8'h40

// field positions of request and single-mask commands
`define DSM_CMD_VAL_BIT     2
`define DSM_CMD_SEL_MSB     1
`define DSM_CMD_SEL_LSB     0

// reset values
`define DSM_SWREQ_RST       8'h00
`define DSM_MASK_RST        8'hff
`define DSM_TCSTAT_RST      8'h00
`define DSM_SVC_RST         8'h00
`define DSM_DREQ_RST        8'h00
`define DSM_IDX_RST         8'h00
`define DSM_RD_RST          8'h00

// the upper group's channel 0 carries the lower group
`define DSM_CASCADE_CH      4

`endif

// ===== verilog/dsm_req_mask.v
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/1ps
`include "dsm_defs.vh"

module dsm_req_mask #(
  parameter NCH = 8
) (
  // clock and reset
  input  wire             mclk,
  input  wire             nrst,
  // ahb-lite slave
  input  wire             hsel,
  input  wire [9:0]       haddr,
  input  wire [1:0]       htrans,
  input  wire             hwrite,
  input  wire [2:0]       hsize,
  input  wire [31:0]      hwdata,
  input  wire             hready,
  output wire             hreadyout,
  output wire             hresp,
  output wire [31:0]      hrdata,
  // peripheral request pins, asynchronous
  input  wire [NCH-1:0]   dreq_pin,
  // from transfer logic, same clock
  input  wire [NCH-1:0]   tc_pulse,
  input  wire [NCH-1:0]   autoinit,
  // to the priority encoder
  output wire [NCH-1:0]   svc_req,
  output wire [NCH-1:0]   sw_req,
  output wire [NCH-1:0]   chan_mask
);

  // channels per group; the upper group's channel 0 carries the lower group
  localparam NGRP = NCH / 2;

  // request, mask and status state
  reg  [NCH-1:0] sw_q;
  reg  [NCH-1:0] sw_d;
  reg  [NCH-1:0] mask_q;
  reg  [NCH-1:0] mask_sw;
  reg  [NCH-1:0] mask_d;
  reg  [NCH-1:0] tcs_q;
  reg  [NCH-1:0] tcs_d;
  reg  [NCH-1:0] svc_q;
  reg  [NCH-1:0] dreq_m_q;
  reg  [NCH-1:0] dreq_s_q;
  reg            mclr_q;
  // bus capture
  reg            wr_q;
  reg  [7:0]     idx_q;
  reg  [7:0]     rd_d;
  reg  [7:0]     rd_q;
  wire           acc;
  wire           rd_acc;
  wire [7:0]     aidx;
  // command byte and its fields
  wire [7:0]     wbyte;
  wire [1:0]     wsel;
  wire           wval;
  // data-phase write strobes, one per command port
  reg            wr_req_lo;
  reg            wr_req_hi;
  reg            wr_smask_lo;
  reg            wr_smask_hi;
  reg            wr_amask_lo;
  reg            wr_amask_hi;
  reg            wr_mclr;
  // address-phase status read strobes
  reg            rd_stat_lo;
  reg            rd_stat_hi;
  // per-group read views
  wire [7:0]     stat_lo;
  wire [7:0]     stat_hi;
  wire [7:0]     amask_lo;
  wire [7:0]     amask_hi;
  // request gating
  wire [NGRP-1:0] lo_eff;
  wire [NCH-1:0] m_eff;
  wire [NCH-1:0] hw_gated;
  wire [NCH-1:0] tc_mask_set;

  // single-channel update shared by request and mask commands
  function [NCH-1:0] upd_bit;
    input [NCH-1:0] v;
    input           hi;
    input [1:0]     sel;
    input           val;
    begin
      upd_bit = v;
      upd_bit[{hi, sel}] = val;
    end
  endfunction

  // whole-group mask load shared by both all-mask ports
  function [NCH-1:0] upd_grp;
    input [NCH-1:0] v;
    input           hi;
    input [7:0]     cmd;
    begin
      upd_grp = v;
      if (hi) begin
        upd_grp[NCH-1:NGRP] = cmd[NGRP-1:0];
      end else begin
        upd_grp[NGRP-1:0] = cmd[NGRP-1:0];
      end
    end
  endfunction

  // status byte of one group: pending requests above, terminal counts below
  function [7:0] stat_view;
    input [NGRP-1:0] pend;
    input [NGRP-1:0] tcs;
    begin
      stat_view = {pend, tcs};
    end
  endfunction

  // mask byte of one group, upper bits reserved as zero
  function [7:0] mask_view;
    input [NGRP-1:0] m;
    begin
      mask_view = {{(8 - NGRP){1'b0}}, m};
    end
  endfunction

  assign acc       = hsel & hready & htrans[1];
  assign rd_acc    = acc & ~hwrite;
  assign aidx      = haddr[9:2];
  assign wbyte     = hwdata[7:0];
  assign wsel      = wbyte[`DSM_CMD_SEL_MSB:`DSM_CMD_SEL_LSB];
  assign wval      = wbyte[`DSM_CMD_VAL_BIT];
  // every register answers from flops, so no wait state is ever needed
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = {24'h00_0000, rd_q};
  assign svc_req   = svc_q;
  assign sw_req    = sw_q;
  assign chan_mask = mask_q;

  // lower group rides on channel 4, so its mask gates all four
  assign lo_eff = mask_q[NGRP-1:0] | {NGRP{mask_q[`DSM_CASCADE_CH]}};
  assign m_eff  = {mask_q[NCH-1:NGRP], lo_eff};

  assign stat_lo  = stat_view(svc_q[NGRP-1:0], tcs_q[NGRP-1:0]);
  assign stat_hi  = stat_view(svc_q[NCH-1:NGRP], tcs_q[NCH-1:NGRP]);
  assign amask_lo = mask_view(mask_q[NGRP-1:0]);
  assign amask_hi = mask_view(mask_q[NCH-1:NGRP]);

  // read data prepared in address phase, presented in data phase
  // write-only ports read as zero, so reserved bits show 0
  always @* begin
    rd_d = 8'h00;
    if (aidx == `DSM_IDX_STAT_LO) begin
      rd_d = stat_lo;
    end else if (aidx == `DSM_IDX_STAT_HI) begin
      rd_d = stat_hi;
    end else if (aidx == `DSM_IDX_AMASK_LO) begin
      rd_d = amask_lo;
    end else if (aidx == `DSM_IDX_AMASK_HI) begin
      rd_d = amask_hi;
    end
  end

  // status reads clear the terminal-count nibble of their group
  always @* begin
    rd_stat_lo = 1'b0;
    rd_stat_hi = 1'b0;
    if (rd_acc && aidx == `DSM_IDX_STAT_LO) begin
      rd_stat_lo = 1'b1;
    end else if (rd_acc && aidx == `DSM_IDX_STAT_HI) begin
      rd_stat_hi = 1'b1;
    end
  end

  // command decode on the index captured in the address phase
  always @* begin
    wr_req_lo   = 1'b0;
    wr_req_hi   = 1'b0;
    wr_smask_lo = 1'b0;
    wr_smask_hi = 1'b0;
    wr_amask_lo = 1'b0;
    wr_amask_hi = 1'b0;
    wr_mclr     = 1'b0;
    if (wr_q && idx_q == `DSM_IDX_REQ_LO) begin
      wr_req_lo = 1'b1;
    end else if (wr_q && idx_q == `DSM_IDX_REQ_HI) begin
      wr_req_hi = 1'b1;
    end else if (wr_q && idx_q == `DSM_IDX_SMASK_LO) begin
      wr_smask_lo = 1'b1;
    end else if (wr_q && idx_q == `DSM_IDX_SMASK_HI) begin
      wr_smask_hi = 1'b1;
    end else if (wr_q && idx_q == `DSM_IDX_AMASK_LO) begin
      wr_amask_lo = 1'b1;
    end else if (wr_q && idx_q == `DSM_IDX_AMASK_HI) begin
      wr_amask_hi = 1'b1;
    end else if (wr_q && idx_q == `DSM_IDX_MCLR) begin
      wr_mclr = 1'b1;
    end
  end

  // tc first, so a request written in the same cycle survives
  always @* begin
    sw_d = sw_q & ~tc_pulse;
    if (wr_req_lo) begin
      sw_d = upd_bit(sw_d, 1'b0, wsel, wval);
    end else if (wr_req_hi) begin
      sw_d = upd_bit(sw_d, 1'b1, wsel, wval);
    end
  end

  // autoinit channels keep their mask open at terminal count
  assign tc_mask_set = tc_pulse & ~autoinit;

  always @* begin
    mask_sw = mask_q;
    if (wr_smask_lo) begin
      mask_sw = upd_bit(mask_sw, 1'b0, wsel, wval);
    end else if (wr_smask_hi) begin
      mask_sw = upd_bit(mask_sw, 1'b1, wsel, wval);
    end else if (wr_amask_lo) begin
      mask_sw = upd_grp(mask_sw, 1'b0, wbyte);
    end else if (wr_amask_hi) begin
      mask_sw = upd_grp(mask_sw, 1'b1, wbyte);
    end
  end

  // hardware set wins over a software clear in the same cycle
  always @* begin
    mask_d = mask_sw | tc_mask_set;
  end

  // set by terminal count wins over the clear of a status read
  always @* begin
    tcs_d = tcs_q;
    if (rd_stat_lo) begin
      tcs_d[NGRP-1:0] = {NGRP{1'b0}};
    end
    if (rd_stat_hi) begin
      tcs_d[NCH-1:NGRP] = {NGRP{1'b0}};
    end
    tcs_d = tcs_d | tc_pulse;
  end

  // hardware request only passes an open effective mask
  assign hw_gated = dreq_s_q & ~m_eff;

  // pin synchroniser first stage; read by the second stage only
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dreq_m_q <= `DSM_DREQ_RST;
    end else begin
      dreq_m_q <= dreq_pin;
    end
  end

  // second stage alone feeds logic
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dreq_s_q <= `DSM_DREQ_RST;
    end else begin
      dreq_s_q <= dreq_m_q;
    end
  end

  // write flag for the data phase
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wr_q <= 1'b0;
    end else begin
      wr_q <= acc & hwrite;
    end
  end

  // index kept for the data-phase decode
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      idx_q <= `DSM_IDX_RST;
    end else begin
      idx_q <= aidx;
    end
  end

  // read data held until the next read is taken
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rd_q <= `DSM_RD_RST;
    end else if (rd_acc) begin
      rd_q <= rd_d;
    end
  end

  // master clear acts one cycle after its data phase
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mclr_q <= 1'b0;
    end else begin
      mclr_q <= wr_mclr;
    end
  end

  // reset-drive output is not an input here, so it cannot touch requests
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sw_q <= `DSM_SWREQ_RST;
    end else if (mclr_q) begin
      sw_q <= `DSM_SWREQ_RST;
    end else begin
      sw_q <= sw_d;
    end
  end

  // all masks closed until software opens them
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mask_q <= `DSM_MASK_RST;
    end else if (mclr_q) begin
      mask_q <= `DSM_MASK_RST;
    end else begin
      mask_q <= mask_d;
    end
  end

  // terminal-count status, cleared with the requests
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tcs_q <= `DSM_TCSTAT_RST;
    end else if (mclr_q) begin
      tcs_q <= `DSM_TCSTAT_RST;
    end else begin
      tcs_q <= tcs_d;
    end
  end

  // registered so the encoder never sees a decode glitch; costs one cycle
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      svc_q <= `DSM_SVC_RST;
    end else begin
      // software request bypasses mask
      svc_q <= sw_q | hw_gated;
    end
  end

endmodule // dsm_req_mask

// ===== tb/dsm_per.sv
`timescale 1ns/1ps
module dsm_per (
  // wanted levels in, request pins out
  input  wire        mclk,
  input  wire  [7:0] want,
  output logic [7:0] dreq_pin
);
  initial dreq_pin = 8'h00;
  always @(posedge mclk) dreq_pin <= want;
endmodule // dsm_per

// ===== tb/dsm_req_mask_sva.sv
`timescale 1ns/1ps
module dsm_chk #(parameter NCH = 8) (
  // watched design ports
  input wire           mclk,
  input wire           nrst,
  input wire           hreadyout,
  input wire           hresp,
  input wire [NCH-1:0] tc_pulse,
  input wire [NCH-1:0] autoinit,
  input wire [NCH-1:0] svc_req,
  input wire [NCH-1:0] sw_req,
  input wire [NCH-1:0] chan_mask
);
  // lower group hides behind channel 4
  wire [NCH-1:0] eff = chan_mask | {4'h0, {4{chan_mask[4]}}};
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  chk_reset_req: assert property ($rose(nrst) |-> !sw_req) else $error("req after reset");
  chk_reset_svc: assert property ($rose(nrst) |-> !svc_req) else $error("svc after reset");
  chk_reset_mask: assert property ($rose(nrst) |-> &chan_mask) else $error("mask after reset");
  chk_bus_okay: assert property (hreadyout && !hresp) else $error("bus wait or error");
  chk_tc_req: assert property (|tc_pulse |=> !(sw_req & $past(tc_pulse))) else $error("tc kept req");
  chk_tc_mask: assert property (|(tc_pulse&~autoinit) |=> &(chan_mask|~$past(tc_pulse)|$past(autoinit)))
    else $error("tc left mask clear");
  chk_sw_bypass: assert property (!($past(sw_req) & ~svc_req)) else $error("sw req lost");
  chk_mask_block: assert property (!(svc_req & ~$past(sw_req) & $past(eff)))
    else $error("masked req served");
  cover property (|tc_pulse);
  cover property (&sw_req);
  cover property (svc_req[0] && !chan_mask[0]);
endmodule // dsm_chk
bind dsm_req_mask dsm_chk #(.NCH(NCH)) u_chk (.mclk, .nrst, .hreadyout, .hresp, .tc_pulse, .autoinit,
  .svc_req, .sw_req, .chan_mask);

// ===== tb/dsm_req_mask_tb.sv
`timescale 1ns/1ps
module dsm_req_mask_tb;
  logic        mclk = 0, nrst = 0, hwrite = 0;
  logic [1:0]  htrans = 2'h0;
  logic [9:0]  haddr = 10'h000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [7:0]  tc_pulse = 8'h00, autoinit = 8'h00, want = 8'h00, rq;
  wire         hreadyout;
  wire  [31:0] hrdata;
  wire  [7:0]  dreq_pin, svc_req, sw_req, chan_mask;
  int          n_mismatch = 0, compares = 0;
  always #12.5 mclk = ~mclk;
  dsm_per u_per (.mclk, .want, .dreq_pin);
  dsm_req_mask u_dut (.mclk, .nrst, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp(), .hrdata, .dreq_pin, .tc_pulse, .autoinit, .svc_req,
    .sw_req, .chan_mask);
  task chk(input string n, input [7:0] e, g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  // address phase held until ready, then data phase
  task bus(input [7:0] i, input w, input [7:0] d);
    @(posedge mclk);
    htrans <= 2'h2;
    haddr <= {i, 2'h0};
    hwrite <= w;
    do @(posedge mclk); while (!hreadyout);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge mclk); while (!hreadyout);
    rq = hrdata[7:0];
  endtask
  task wt(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task report_and_stop;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    wt(4000);
    n_mismatch++;
    report_and_stop;
  end
  initial begin
    repeat (6) @(posedge mclk);
    nrst <= 1;
    wt(1);
    chk("mask", 8'hff, chan_mask);
    chk("req", 8'h00, sw_req);
    for (int c = 0; c < 8; c++) bus(c < 4 ? 8'h0a : 8'hd4, 1, {6'h0, c[1:0]});
    bus(8'h0f, 0, 8'h00);
    chk("amask", 8'h00, rq);
    want <= 8'h01;
    wt(5);
    chk("svc", 8'h01, svc_req);
    bus(8'hd4, 1, 8'h04);
    wt(5);
    chk("svc", 8'h00, svc_req);
    for (int c = 0; c < 8; c++) bus(c < 4 ? 8'h09 : 8'hd2, 1, {6'h1, c[1:0]});
    bus(8'hd2, 1, 8'h01);
    wt(2);
    chk("req", 8'hdf, sw_req);
    chk("svc", 8'hdf, svc_req);
    bus(8'h08, 0, 8'h00);
    chk("stat", 8'hf0, rq);
    tc_pulse <= 8'h06;
    autoinit <= 8'h04;
    @(posedge mclk);
    tc_pulse <= 8'h00;
    wt(2);
    chk("req", 8'hd9, sw_req);
    chk("mask", 8'h12, chan_mask);
    bus(8'h08, 0, 8'h00);
    chk("statlo", 8'h96, rq);
    bus(8'h08, 0, 8'h00);
    chk("statclr", 8'h90, rq);
    bus(8'hd0, 0, 8'h00);
    chk("stathi", 8'hd0, rq);
    bus(8'hde, 0, 8'h00);
    chk("amaskhi", 8'h01, rq);
    bus(8'h09, 0, 8'h00);
    chk("rreq", 8'h00, rq);
    bus(8'h40, 1, 8'h00);
    wt(3);
    chk("req", 8'h00, sw_req);
    chk("mask", 8'hff, chan_mask);
    report_and_stop;
  end
endmodule // dsm_req_mask_tb
